/* sbm_mode_ctrl.sv */
// Serial bus mode control: AHB-Lite registers, pin conditioning, sequencer
//
// Summary of operation
// - Bit 7 low shifts MSB first, high shifts LSB first; resets low.
// - Two-wire master with wait set adds two clocks of low time before ack.
// - Wait clear: data bits and ack run back to back.
// - Wait setting has no effect as slave or in synchronous format.
// - Mode bits 5 and 4 read as one and ignore writes.
// - A mode write with guard bit 3 at zero loads the bit counter.
// - Guard written one discards the count; guard always reads one.
// - Counter sets next frame length, reads bits left, returns to zero after.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sbm_mode_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import sbm_pkg::*;

   // ==========================================================
   // Register state
   logic bos_q, bos_d;
   logic wait_q, wait_d;
   logic [2:0] bc_q, bc_d;
   logic tw_q, tw_d;
   logic mst_q, mst_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] wa_q, wa_d;
   logic wr_q, wr_d;
   logic [31:0] rd_q, rd_d;
   logic [7:0] div_q, div_d;
   logic [2:0] scl_s_q, scl_s_d;
   logic [2:0] sda_s_q, sda_s_d;
   logic scl_f_q, scl_f_d;
   logic sda_f_q, sda_f_d;
   logic scl_oe_q, scl_oe_d;
   logic sda_oe_q, sda_oe_d;
   logic sda_o_q, sda_o_d;

   logic addr_ok, go, tick;
   logic x_busy, x_done, x_ack, x_scl_low, x_sda;
   logic [3:0] x_rem;
   logic [7:0] x_rx;
   logic [7:0] mode_rd;
   logic [2:0] bc_rd;

   // ==========================================================
   // Bus address phase, zero wait state
   assign addr_ok = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_q;

   always_comb begin
      // While a frame runs the counter shows the bits still to go
      // Next values are read so a read right behind a write already sees it
      bc_rd = x_busy ? sbm_bits_to_code(x_rem, tw_q) : bc_d;
      mode_rd = 8'h00;
      mode_rd[SBM_BOS_BIT] = bos_d;
      mode_rd[SBM_WAIT_BIT] = wait_d;
      mode_rd[SBM_RSV_HI_BIT:SBM_RSV_LO_BIT] = SBM_RSV_VAL;
      mode_rd[SBM_GUARD_BIT] = SBM_GUARD_RD;
      mode_rd[SBM_BC_MSB:SBM_BC_LSB] = bc_rd;
      wa_d = wa_q;
      wr_d = 1'b0;
      rd_d = rd_q;
      if (addr_ok) begin
         wa_d = haddr;
         wr_d = hwrite;
         rd_d = 32'h0000_0000;
         if (!hwrite) begin
            unique case (haddr)
               SBM_MODE_OFS: rd_d = {24'h00_0000, mode_rd};
               SBM_CTRL_OFS: begin
                  rd_d[SBM_CTRL_TW_BIT] = tw_d;
                  rd_d[SBM_CTRL_MST_BIT] = mst_d;
               end
               SBM_STAT_OFS: begin
                  rd_d[SBM_STAT_BUSY_BIT] = x_busy;
                  rd_d[SBM_STAT_ACK_BIT] = x_ack;
               end
               SBM_DATA_OFS: rd_d = {24'h00_0000, x_rx};
               default: rd_d = 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Data phase writes
   always_comb begin
      bos_d = bos_q;
      wait_d = wait_q;
      bc_d = bc_q;
      tw_d = tw_q;
      mst_d = mst_q;
      tx_d = tx_q;
      go = 1'b0;
      if (wr_q) begin
         unique case (wa_q)
            SBM_MODE_OFS: begin
               bos_d = hwdata[SBM_BOS_BIT];
               wait_d = hwdata[SBM_WAIT_BIT];
               // Bits 5 and 4 have no storage at all
               if (!hwdata[SBM_GUARD_BIT]) begin
                  bc_d = hwdata[SBM_BC_MSB:SBM_BC_LSB];
               end
            end
            SBM_CTRL_OFS: begin
               // Format and role are frozen while a frame runs
               if (!x_busy) begin
                  tw_d = hwdata[SBM_CTRL_TW_BIT];
                  mst_d = hwdata[SBM_CTRL_MST_BIT];
                  go = hwdata[SBM_CTRL_GO_BIT];
               end
            end
            SBM_DATA_OFS: begin
               if (!x_busy) begin
                  tx_d = hwdata[7:0];
               end
            end
            default: begin
            end
         endcase
      end
      // End of frame wins over a software load in the same cycle
      if (x_done) begin
         bc_d = SBM_BC_RST;
      end
   end

   // ==========================================================
   // Half-period divider, restarted between frames so the first low is full
   always_comb begin
      tick = 1'b0;
      div_d = 8'h00;
      if (x_busy && mst_q) begin
         if (div_q == 8'(SBM_HALF_CYC - 8'h01)) begin
            tick = 1'b1;
         end else begin
            div_d = 8'(div_q + 8'h01);
         end
      end
   end

   // ==========================================================
   // Pin conditioning: three stages, a change counts when stages two and three agree
   always_comb begin
      scl_s_d = {scl_s_q[1:0], scl_i};
      sda_s_d = {sda_s_q[1:0], sda_i};
      scl_f_d = (scl_s_q[2] == scl_s_q[1]) ? scl_s_q[2] : scl_f_q;
      sda_f_d = (sda_s_q[2] == sda_s_q[1]) ? sda_s_q[2] : sda_f_q;
      // Two-wire pins are open drain; synchronous data is push-pull
      scl_oe_d = x_scl_low;
      sda_oe_d = x_busy && (tw_q ? !x_sda : 1'b1);
      sda_o_d = tw_q ? 1'b0 : x_sda;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bos_q <= SBM_BOS_RST;
         wait_q <= SBM_WAIT_RST;
         bc_q <= SBM_BC_RST;
         tw_q <= SBM_TW_RST;
         mst_q <= SBM_MST_RST;
         tx_q <= SBM_TX_RST;
         wa_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         div_q <= 8'h00;
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         sda_f_q <= 1'b1;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         sda_o_q <= 1'b0;
      end else begin
         bos_q <= bos_d;
         wait_q <= wait_d;
         bc_q <= bc_d;
         tw_q <= tw_d;
         mst_q <= mst_d;
         tx_q <= tx_d;
         wa_q <= wa_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         div_q <= div_d;
         scl_s_q <= scl_s_d;
         sda_s_q <= sda_s_d;
         scl_f_q <= scl_f_d;
         sda_f_q <= sda_f_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         sda_o_q <= sda_o_d;
      end
   end

   assign scl_o = 1'b0;
   assign scl_oe = scl_oe_q;
   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;

   // ==========================================================
   // Sequencer
   sbm_xfer u_xfer (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(go),
      .two_wire(tw_q),
      .master(mst_q),
      .lsb_first(bos_q),
      .wait_en(wait_q),
      .nbits(sbm_code_to_bits(bc_q, tw_q)),
      .tx_data(tx_q),
      .tick(tick),
      .scl_rise(scl_f_d && !scl_f_q),
      .scl_fall(!scl_f_d && scl_f_q),
      .sda_in(sda_f_q),
      .busy(x_busy),
      .done(x_done),
      .rem(x_rem),
      .rx_data(x_rx),
      .ack_rx(x_ack),
      .scl_low(x_scl_low),
      .sda_bit(x_sda)
   );

endmodule : sbm_mode_ctrl

/* sbm_mode_ctrl_bench.sv */
// Self-checking bench for the serial bus mode control block
`timescale 1ns/1ps
module sbm_mode_ctrl_bench;
   import sbm_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, sda_pull, scl_pull, scl_w, sda_w;
   logic clr = 1'b1;
   logic ack_en = 1'b0;
   logic clk_run = 1'b0;
   logic [7:0] p_rx;
   logic [3:0] p_rises;
   logic [9:0] p_low;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   // Both lines pulled up; any party may pull low
   assign scl_w = (scl_oe ? scl_o : 1'b1) && !scl_pull;
   assign sda_w = (sda_oe ? sda_o : 1'b1) && !sda_pull;
   initial begin
      forever #25 hclk = ~hclk;
   end
   sbm_mode_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
   sbm_partner u_far (.hclk(hclk), .clr(clr), .ack_en(ack_en), .clk_run(clk_run),
      .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .scl_pull(scl_pull), .rx_q(p_rx),
      .rises_q(p_rises), .low_q(p_low));
   // ==========================================================
   // Checking and bus tasks
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask : cmp_reg
   task automatic cmp_cnt(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : cmp_cnt
   // Entered just after a rising edge; holds each phase until ready is seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd,
      output logic [7:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] unused;
      bus(1'b1, a, d, unused);
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] got;
      bus(1'b0, a, 8'h00, got);
      cmp_reg(got, exp);
   endtask : chk
   task automatic frame(input logic [7:0] c, input logic [7:0] m, input logic [7:0] tx,
      input logic ack);
      logic [7:0] st;
      int n;
      wr(SBM_MODE_OFS, m);
      wr(SBM_DATA_OFS, tx);
      wr(SBM_CTRL_OFS, c);
      clr <= 1'b1;
      ack_en <= ack;
      clk_run <= !c[1];
      @(posedge hclk);
      clr <= 1'b0;
      wr(SBM_CTRL_OFS, c | 8'h04);
      repeat (4) @(posedge hclk);
      st = 8'h01;
      n = 0;
      while (st[0] !== 1'b0 && n < 3000) begin
         bus(1'b0, SBM_STAT_OFS, 8'h00, st);
         n++;
      end
      cmp_reg({7'h0, st[0]}, 8'h00);
   endtask : frame
   // ==========================================================
   // Scenarios
   task automatic t_fields();
      chk(SBM_MODE_OFS, 8'h38);
      wr(SBM_MODE_OFS, 8'hFF);
      chk(SBM_MODE_OFS, 8'hF8);
      wr(SBM_MODE_OFS, 8'h05);
      chk(SBM_MODE_OFS, 8'h3D);
      wr(SBM_MODE_OFS, 8'h0B);
      chk(SBM_MODE_OFS, 8'h3D);
      chk(8'h10, 8'h00);
      $display("test fields done");
   endtask : t_fields
   task automatic t_tw_plain();
      frame(8'h03, 8'h00, 8'hA5, 1'b1);
      cmp_cnt(10'(p_rises), 10'h009);
      cmp_reg(p_rx, 8'hA5);
      cmp_cnt(p_low, 10'h064);
      chk(SBM_MODE_OFS, 8'h38);
      chk(SBM_STAT_OFS, 8'h00);
      chk(SBM_DATA_OFS, 8'hA5);
      $display("test two-wire plain done");
   endtask : t_tw_plain
   task automatic t_tw_wait();
      frame(8'h03, 8'h40, 8'h3C, 1'b1);
      cmp_cnt(10'(p_rises), 10'h009);
      cmp_cnt(p_low, 10'h1F4);
      cmp_reg(p_rx, 8'h3C);
      $display("test two-wire wait done");
   endtask : t_tw_wait
   task automatic t_sync_lsb();
      logic [7:0] tx;
      tx = 8'h35;
      frame(8'h02, 8'hC8, tx, 1'b0);
      cmp_cnt(10'(p_rises), 10'h008);
      cmp_cnt(p_low, 10'h064);
      cmp_reg(p_rx, 8'hAC);
      chk(SBM_DATA_OFS, tx);
      $display("test synchronous lsb done");
   endtask : t_sync_lsb
   task automatic t_tw_count();
      frame(8'h03, 8'h03, 8'hFF, 1'b0);
      cmp_cnt(10'(p_rises), 10'h004);
      cmp_reg(p_rx, 8'h0F);
      chk(SBM_MODE_OFS, 8'h38);
      chk(SBM_STAT_OFS, 8'h02);
      $display("test short count done");
   endtask : t_tw_count
   task automatic t_tw_slave();
      frame(8'h01, 8'h40, 8'h96, 1'b1);
      cmp_reg(p_rx, 8'h96);
      cmp_cnt(p_low, 10'h032);
      chk(SBM_STAT_OFS, 8'h00);
      chk(SBM_MODE_OFS, 8'h78);
      $display("test two-wire slave done");
   endtask : t_tw_slave
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_fields();
      t_tw_plain();
      t_tw_wait();
      t_sync_lsb();
      t_tw_count();
      t_tw_slave();
      give_verdict();
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         give_verdict();
      end
   end
endmodule : sbm_mode_ctrl_bench

/* sbm_partner.sv */
// Far-side serial device: samples data on clock rise, acks, times low periods
`timescale 1ns/1ps
module sbm_partner (
   input wire logic hclk,
   input wire logic clr,
   input wire logic ack_en,
   input wire logic clk_run,
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull,
   output logic scl_pull,
   output logic [7:0] rx_q,
   output logic [3:0] rises_q,
   output logic [9:0] low_q
);
   logic scl_q;
   logic [9:0] run_q;
   logic [6:0] ph_q;
   logic [3:0] nclk_q;
   always_ff @(posedge hclk) begin
      scl_q <= scl;
      run_q <= scl ? 10'h000 : run_q + 10'h001;
      if (clr) begin
         rises_q <= 4'h0;
         rx_q <= 8'h00;
         low_q <= 10'h000;
         sda_pull <= 1'b0;
         ph_q <= 7'h00;
         nclk_q <= 4'h0;
         scl_pull <= 1'b0;
      end else begin
         // Own clock when the block is slave: ten low-first periods, then idle high
         if (clk_run && nclk_q != 4'hA) begin
            scl_pull <= (ph_q < 7'h32);
            ph_q <= (ph_q == 7'h63) ? 7'h00 : 7'(ph_q + 7'h01);
            if (ph_q == 7'h63) begin
               nclk_q <= 4'(nclk_q + 4'h1);
            end
         end else begin
            scl_pull <= 1'b0;
         end
         // Ack only changes data while the clock is low
         if (ack_en && rises_q == 4'h8 && !scl) begin
            sda_pull <= 1'b1;
         end
         if (scl && !scl_q) begin
            rises_q <= rises_q + 4'h1;
            // Longest low kept, so the wait shows wherever it lands
            low_q <= (run_q > low_q) ? run_q : low_q;
            if (rises_q < 4'h8) begin
               rx_q <= {rx_q[6:0], sda};
            end
         end
      end
   end
endmodule : sbm_partner

/* sbm_pkg.sv */
// Package of constants, types and helpers for the serial bus mode control block
package sbm_pkg;

   // ==========================================================
   // Register map (word aligned byte addresses)
   localparam logic [7:0] SBM_MODE_OFS = 8'h00;
   localparam logic [7:0] SBM_CTRL_OFS = 8'h04;
   localparam logic [7:0] SBM_STAT_OFS = 8'h08;
   localparam logic [7:0] SBM_DATA_OFS = 8'h0C;

   // ==========================================================
   // Mode register fields
   localparam int SBM_BOS_BIT = 7;
   localparam int SBM_WAIT_BIT = 6;
   localparam int SBM_RSV_HI_BIT = 5;
   localparam int SBM_RSV_LO_BIT = 4;
   localparam int SBM_GUARD_BIT = 3;
   localparam int SBM_BC_MSB = 2;
   localparam int SBM_BC_LSB = 0;
   localparam logic [1:0] SBM_RSV_VAL = 2'h3;
   localparam logic SBM_GUARD_RD = 1'b1;
   localparam logic SBM_BOS_RST = 1'b0;
   localparam logic SBM_WAIT_RST = 1'b0;
   localparam logic [2:0] SBM_BC_RST = 3'h0;

   // ==========================================================
   // Control and status fields
   localparam int SBM_CTRL_TW_BIT = 0;
   localparam int SBM_CTRL_MST_BIT = 1;
   localparam int SBM_CTRL_GO_BIT = 2;
   localparam logic SBM_TW_RST = 1'b1;
   localparam logic SBM_MST_RST = 1'b0;
   localparam int SBM_STAT_BUSY_BIT = 0;
   localparam int SBM_STAT_ACK_BIT = 1;
   localparam logic [7:0] SBM_TX_RST = 8'h00;

   // ==========================================================
   // Timing
   localparam int SBM_CLK_PERIOD_NS = 50;
   localparam int SBM_HALF_PERIOD_NS = 5000;
   localparam int SBM_HALF_CYC_INT =
      (SBM_HALF_PERIOD_NS + SBM_CLK_PERIOD_NS - 1) / SBM_CLK_PERIOD_NS;
   localparam logic [7:0] SBM_HALF_CYC = 8'(SBM_HALF_CYC_INT);
   localparam logic [2:0] SBM_WAIT_HALVES = 3'h4;
   localparam logic [3:0] SBM_BITS_TW0 = 4'h9;
   localparam logic [3:0] SBM_BITS_SY0 = 4'h8;

   // ==========================================================
   // Transfer sequencer states, Gray along idle-low-high-wait
   typedef enum logic [1:0] {
      SBM_IDLE = 2'b00,
      SBM_LOW = 2'b01,
      SBM_HIGH = 2'b11,
      SBM_WAIT = 2'b10
   } sbm_state_e;

   // Bit counter code to number of bits in the transfer
   function automatic logic [3:0] sbm_code_to_bits(input logic [2:0] code, input logic tw);
      if (code == 3'h0) begin
         return tw ? SBM_BITS_TW0 : SBM_BITS_SY0;
      end
      return tw ? 4'({1'b0, code} + 4'h1) : {1'b0, code};
   endfunction : sbm_code_to_bits

   // Bits remaining back to the counter code
   function automatic logic [2:0] sbm_bits_to_code(input logic [3:0] bits, input logic tw);
      return tw ? 3'(bits - 4'h1) : bits[2:0];
   endfunction : sbm_bits_to_code

endpackage : sbm_pkg

/* sbm_properties.sv */
// Concurrent checks on the ports of the serial bus mode control block
`timescale 1ns/1ps
module sbm_properties
   import sbm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe
);
   // ==========================================================
   // Helper: length of each clock-low drive
   logic [9:0] hi_len_q;
   logic [9:0] hi_len_d;
   always_comb begin
      hi_len_d = scl_oe ? hi_len_q + 10'h001 : 10'h000;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_len_q <= 10'h000;
      end else begin
         hi_len_q <= hi_len_d;
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence mode_rd;
      hsel && hready && htrans[1] && !hwrite && haddr == SBM_MODE_OFS;
   endsequence
   sequence mode_load;
      hsel && hready && htrans[1] && hwrite && haddr == SBM_MODE_OFS ##1 !hwdata[3];
   endsequence
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_zero_wait: assert property (hreadyout == 1'b1)
      else $error("bus ready dropped");
   chk_reserved_ones: assert property (mode_rd |=> hrdata[5:4] == 2'h3)
      else $error("reserved mode bits not one");
   chk_guard_reads: assert property (mode_rd |=> hrdata[3] == 1'b1)
      else $error("guard bit not read as one");
   chk_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite &&
      (haddr > SBM_DATA_OFS || haddr[1:0] != 2'h0) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_count_load: assert property (mode_load ##1 mode_rd |=>
      hrdata[2:0] == $past(hwdata[2:0], 2))
      else $error("count not loaded");
   chk_low_length: assert property ($fell(scl_oe) |->
      hi_len_q == 10'h064 || hi_len_q == 10'h1F4)
      else $error("clock low period wrong");
   chk_reset_idle: assert property ($rose(hresetn) |->
      !scl_oe && !sda_oe && hrdata == 32'h0)
      else $error("pins or data not idle after reset");
endmodule : sbm_properties

bind sbm_mode_ctrl sbm_properties u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

/* sbm_xfer.sv */
// Bit sequencer: shifts one frame, counts bits and inserts the master wait
`timescale 1ns/1ps
module sbm_xfer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic two_wire,
   input wire logic master,
   input wire logic lsb_first,
   input wire logic wait_en,
   input wire logic [3:0] nbits,
   input wire logic [7:0] tx_data,
   input wire logic tick,
   input wire logic scl_rise,
   input wire logic scl_fall,
   input wire logic sda_in,
   output logic busy,
   output logic done,
   output logic [3:0] rem,
   output logic [7:0] rx_data,
   output logic ack_rx,
   output logic scl_low,
   output logic sda_bit
);
   import sbm_pkg::*;

   sbm_state_e state_q, state_d;
   logic [3:0] rem_q, rem_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] wcnt_q, wcnt_d;
   logic smp_q, smp_d;
   logic ack_q, ack_d;
   logic adv_low, adv_high, ack_slot, shifted_in;

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;
      rem_d = rem_q;
      sh_d = sh_q;
      wcnt_d = wcnt_q;
      smp_d = smp_q;
      ack_d = ack_q;
      done = 1'b0;
      // Slave follows the partner's clock edges, master its own divider
      adv_low = master ? tick : scl_rise;
      adv_high = master ? tick : scl_fall;
      ack_slot = two_wire && (rem_q == 4'h1);
      shifted_in = smp_q;
      unique case (state_q)
         SBM_IDLE: begin
            if (start) begin
               state_d = SBM_LOW;
               rem_d = nbits;
               sh_d = tx_data;
            end
         end
         SBM_LOW: begin
            if (adv_low) begin
               state_d = SBM_HIGH;
               smp_d = sda_in;
            end
         end
         SBM_HIGH: begin
            if (adv_high) begin
               rem_d = 4'(rem_q - 4'h1);
               if (ack_slot) begin
                  ack_d = shifted_in;
               end else if (lsb_first) begin
                  sh_d = {shifted_in, sh_q[7:1]};
               end else begin
                  sh_d = {sh_q[6:0], shifted_in};
               end
               if (rem_q == 4'h1) begin
                  state_d = SBM_IDLE;
                  done = 1'b1;
               end else if (master && two_wire && wait_en && rem_q == 4'h2) begin
                  state_d = SBM_WAIT;
                  wcnt_d = 3'(SBM_WAIT_HALVES - 3'h1);
               end else begin
                  state_d = SBM_LOW;
               end
            end
         end
         SBM_WAIT: begin
            // Two full transfer clocks of extra low time before the ack
            if (tick) begin
               if (wcnt_q == 3'h0) begin
                  state_d = SBM_LOW;
               end else begin
                  wcnt_d = 3'(wcnt_q - 3'h1);
               end
            end
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= SBM_IDLE;
         rem_q <= 4'h0;
         sh_q <= 8'h00;
         wcnt_q <= 3'h0;
         smp_q <= 1'b0;
         ack_q <= 1'b1;
      end else begin
         state_q <= state_d;
         rem_q <= rem_d;
         sh_q <= sh_d;
         wcnt_q <= wcnt_d;
         smp_q <= smp_d;
         ack_q <= ack_d;
      end
   end

   assign busy = (state_q != SBM_IDLE);
   assign rem = rem_q;
   assign rx_data = sh_q;
   assign ack_rx = ack_q;
   assign scl_low = master && (state_q == SBM_LOW || state_q == SBM_WAIT);
   // The ack slot is released so the partner can answer
   assign sda_bit = (two_wire && rem_q == 4'h1) ? 1'b1 : (lsb_first ? sh_q[0] : sh_q[7]);

endmodule : sbm_xfer
